// ### bench/i2c_far_side_model.sv
// Far-side model: a target that acknowledges one address, and a small
// bus master run by tasks. Assumes pulled-up wires resolved by the bench.
`timescale 1ns/10ps
module i2c_far_side_model #(
	parameter logic [6:0] SLV_ADDR = 7'h2B,
	parameter int HALF = 50
) (
	input wire logic ref_clk,
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_oe,
	output logic sda_oe
);
	logic tgt_on;
	logic [7:0] rx_q[$];
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		tgt_on = 1'b0;
	end
	// ----------------------------------------
	// Target side
	// ----------------------------------------
	task automatic rx_frame();
		logic [7:0] b;
		logic hit;
		logic first;
		first = 1'b1;
		hit = 1'b0;
		forever begin
			for (int i = 0; i < 8; i++) begin
				@(posedge scl_w);
				b = {b[6:0], sda_w};
			end
			@(negedge scl_w);
			if (first) hit = (b[7:1] == SLV_ADDR);
			first = 1'b0;
			if (hit) begin
				rx_q.push_back(b);
				sda_oe <= 1'b1;
			end
			@(negedge scl_w);
			// Hold past the falling edge so the data hold time is kept
			#100 sda_oe <= 1'b0;
		end
	endtask
	always begin
		@(negedge sda_w iff (scl_w === 1'b1 && tgt_on === 1'b1));
		fork
			rx_frame();
			@(posedge sda_w iff scl_w === 1'b1);
		join_any
		disable fork;
		sda_oe <= 1'b0;
	end
	// ----------------------------------------
	// Master side
	// ----------------------------------------
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic scl_up();
		scl_oe <= 1'b0;
		// Bounded wait: the port may stretch the clock low
		for (int i = 0; i < 5000 && scl_w !== 1'b1; i++) @(posedge ref_clk);
	endtask
	task automatic send_addr(input logic [7:0] b, input int glitch, output logic ack);
		sda_oe <= 1'b1;
		hold(HALF);
		scl_oe <= 1'b1;
		for (int i = 7; i >= -1; i--) begin
			sda_oe <= (i >= 0) ? ~b[i] : 1'b0;
			hold(HALF);
			scl_up();
			hold(HALF / 2);
			if (i == 6 && glitch > 0) begin
				sda_oe <= 1'b1;
				hold(glitch);
				sda_oe <= 1'b0;
			end
			hold(HALF / 2);
			ack = sda_w;
			scl_oe <= 1'b1;
		end
		hold(HALF / 2);
		sda_oe <= 1'b1;
	endtask
	task automatic send_stop();
		scl_up();
		hold(HALF);
		sda_oe <= 1'b0;
		hold(HALF);
	endtask
endmodule : i2c_far_side_model

// ### bench/tb_i2c_smbus_port_filter.sv
// Self-checking bench for the I2C/SMBus port with glitch filter
// Assumes the far-side model file and the design package are compiled first
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_i2c_smbus_port_filter;
	import i2c_port_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq, scl_out, scl_oe, sda_out, sda_oe, p_scl_oe, p_sda_oe;
	logic [31:0] hrdata;
	logic scl_w, sda_w, ack;
	int miscompares = 0;
	int samples_checked = 0;
	int half;
	time last_rise, prev_rise;
	logic [7:0] v, d;
	logic [7:0] exp_q[$];
	logic [7:0] t_cfg [7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h47, 8'h00, 8'h00};
	logic [7:0] t_byte [7] = '{8'h66, 8'h44, 8'h00, 8'h00, 8'hF6, 8'h66, 8'h66};
	int t_filt [7] = '{0, 0, 0, 0, 0, 15, 0};
	int t_glitch [7] = '{0, 0, 0, 0, 0, 8, 8};
	logic t_hit [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0] t_ofs [3] = '{OFS_OWN, OFS_CFG, OFS_FILT};
	logic [7:0] t_msk [3] = '{OWN_WMASK, CFG_WMASK, FILT_WMASK};
	// Open-drain wires with pull-ups
	assign scl_w = ~(scl_oe | p_scl_oe);
	assign sda_w = ~(sda_oe | p_sda_oe);
	always #5 ref_clk = ~ref_clk;
	always @(posedge scl_w) begin
		prev_rise = last_rise;
		last_rise = $time;
	end
	i2c_smbus_port_filter u_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .irq(irq));
	i2c_far_side_model #(.SLV_ADDR(7'h2B), .HALF(50)) p_model (.ref_clk(ref_clk),
		.scl_w(scl_w), .sda_w(sda_w), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata[7:0];
		`CHK({hresp, hrdata[31:8]}, 25'h0)
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		logic [7:0] x;
		ahb(1'b1, a, wd, x);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		ahb(1'b0, a, 8'h00, x);
		`CHK(x, e)
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 8000 && irq !== 1'b1; i++) @(posedge ref_clk);
	endtask
	task automatic end_test(input string name);
		$display("test %s done, mismatches so far %0d", name, miscompares);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#300_000;
		miscompares++;
		$display("watchdog expired");
		finish_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'h8719F397));
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			chk_rd(8'(i * 4), (i == 7) ? MASK_RESET : REG_RESET);
		end
		`CHK(irq, 1'b0)
		`CHK({scl_out, sda_out, scl_oe, sda_oe}, 4'h0)
		end_test("reset");
		// Writable bits only, random values; unmapped place reads zero
		for (int i = 0; i < 3; i++) begin
			v = 8'($urandom);
			wr(t_ofs[i], v);
			chk_rd(t_ofs[i], v & t_msk[i]);
			wr(t_ofs[i], 8'h00);
		end
		wr(8'h20, 8'hFF);
		chk_rd(8'h20, 8'h00);
		end_test("registers");
		// Master transmit: address then one random byte
		v = {2'($urandom % 3), 6'($urandom % 4)};
		half = (v[7] ? 4 : (v[6] ? 2 : 1)) * (20 + 4 * v[5:0]);
		p_model.tgt_on = 1'b1;
		wr(OFS_RATE, v);
		wr(OFS_CTL, 8'hC0);
		wr(OFS_CTL, 8'hD0);
		wr(OFS_CTL, 8'hF0);
		wr(OFS_DATA, 8'h56);
		exp_q.push_back(8'h56);
		wait_irq();
		chk_rd(OFS_STAT, 8'h80 | 8'h20 | 8'h02);
		wr(OFS_STAT, EVENT_BITS);
		d = 8'($urandom);
		wr(OFS_DATA, d);
		exp_q.push_back(d);
		wait_irq();
		`CHK(irq, 1'b1)
		v = (last_rise - prev_rise >= 20 * half && last_rise - prev_rise <= 20 * half + 100);
		`CHK(v[0], 1'b1)
		wr(OFS_MASK, 8'h00);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wr(OFS_MASK, 8'h02);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		wr(OFS_STAT, EVENT_BITS);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wr(OFS_CTL, 8'hC0);
		repeat (600) @(posedge ref_clk);
		p_model.tgt_on = 1'b0;
		`CHK(p_model.rx_q.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(p_model.rx_q[i], exp_q[i])
		end_test("master transmit");
		// Slave addressing, general call, 10-bit header and the filter
		wr(OFS_OWN, 8'h66);
		for (int i = 0; i < 7; i++) begin
			wr(OFS_CFG, t_cfg[i]);
			wr(OFS_FILT, 8'(t_filt[i]));
			wr(OFS_CTL, 8'hC0);
			p_model.send_addr(t_byte[i], t_glitch[i], ack);
			repeat (40) @(posedge ref_clk);
			`CHK({ack, irq}, {~t_hit[i], t_hit[i]})
			if (t_hit[i]) begin
				chk_rd(OFS_STAT, 8'h40 | 8'h02 | 8'h20);
				chk_rd(OFS_DATA, t_byte[i]);
				wr(OFS_STAT, EVENT_BITS);
			end
			p_model.send_stop();
			end_test("slave address");
		end
		finish_test();
	end
endmodule : tb_i2c_smbus_port_filter

// ### rtl/i2c_port_pkg.sv
// Constants and types for the I2C/SMBus port with input glitch filter
// Assumes one 100 MHz clock and word-aligned AHB-Lite register access
package i2c_port_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_OWN = 8'h00;
	localparam logic [7:0] OFS_RATE = 8'h04;
	localparam logic [7:0] OFS_CTL = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_FILT = 8'h18;
	localparam logic [7:0] OFS_MASK = 8'h1C;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_EN = 7;
	localparam int CTL_IE = 6;
	localparam int CTL_MST = 5;
	localparam int CTL_TX = 4;
	localparam int CTL_ACK_RESPONSE_SELECT = 3;
	localparam int CTL_REPEAT_START_REQUEST = 2;
	localparam int ST_DONE = 7;
	localparam int ST_AAS = 6;
	localparam int ST_ARBITRATION_LOST_FLAG = 4;
	localparam int ST_IRQF = 1;
	localparam int CFG_GCEN = 7;
	localparam int CFG_EXT = 6;
	// ----------------------------------------
	// Write masks, reset values, codes
	// ----------------------------------------
	localparam logic [7:0] OWN_WMASK = 8'hFE;
	localparam logic [7:0] CTL_WMASK = 8'hFC;
	localparam logic [7:0] CFG_WMASK = 8'hC7;
	localparam logic [7:0] FILT_WMASK = 8'h0F;
	localparam logic [7:0] EVENT_BITS = 8'hD2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h02;
	localparam logic [7:0] GEN_CALL = 8'h00;
	localparam logic [4:0] ADDR10_HDR = 5'h1E;
	localparam logic [15:0] DIV_BASE = 16'h0014;
	localparam logic [15:0] DIV_STEP = 16'h0004;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
	} line_pair_type;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_LOW = 3'b010,
		M_HIGH = 3'b011,
		M_WAIT = 3'b100,
		M_STOP = 3'b101,
		M_RSTART = 3'b110
	} mst_state_type;
endpackage : i2c_port_pkg

// ### rtl/i2c_smbus_port_filter.sv
// I2C/SMBus port: AHB-Lite registers, glitch filter, master and slave engine
// Assumes open-drain pads outside; oe high pulls the line low
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module i2c_smbus_port_filter
	import i2c_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic irq
);
	line_pair_type sync1_q, sync2_q, filt_q, prev_q;
	logic [1:0][3:0] fcnt_q;
	logic pend_q, wr_q, hready_q, hresp_q, irq_q, scl_oe_q, sda_oe_q, zero_q;
	logic [7:0] addr_q, rd_mux;
	logic [31:0] hrdata_q;
	logic [7:0] own_q, rate_q, ctl_q, cfg_q, filter_q, mask_q, data_q;
	logic done_q, aas_q, arbitration_lost_flag_q, irqf_q, busy_q;
	logic wr_data, rd_data, wr_en, go;
	logic [7:0] wdata, status;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [15:0] div_cnt_q, half;
	logic tick_q;
	mst_state_type mst_q;
	logic [3:0] mbit_q;
	logic [7:0] msh_q;
	logic mrx_q, mdir_q, maddr_q, m_scl_lo_q, m_sda_lo_q;
	logic m_done_q, m_arbitration_lost_flag_q, m_received_ack_q, m_rs_used_q;
	logic sact_q, saddr_q, stx_q, s10_q, s_first10_q, s_sda_lo_q, s_hold_q;
	logic s_srw_q, s_done_q, s_aas_q;
	logic [3:0] sbit_q;
	logic [7:0] ssh_q;
	logic own7, gcall, hdr10, smatch;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// One wait state per transfer keeps read data registered
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pend_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			hready_q <= 1'b1;
			hrdata_q <= 32'h0000_0000;
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
			if (pend_q) begin
				pend_q <= 1'b0;
				hready_q <= 1'b1;
				if (!wr_q) begin
					hrdata_q <= {24'h00_0000, rd_mux};
				end
			end else if (hsel && htrans[1] && hready) begin
				pend_q <= 1'b1;
				hready_q <= 1'b0;
				addr_q <= haddr[7:0];
				wr_q <= hwrite;
			end
		end
	end

	assign wdata = hwdata[7:0];
	assign wr_en = pend_q && wr_q;
	assign wr_data = wr_en && addr_q == OFS_DATA;
	assign rd_data = pend_q && !wr_q && addr_q == OFS_DATA;
	assign status = {done_q, aas_q, busy_q, arbitration_lost_flag_q, 1'b0, s_srw_q, irqf_q, m_received_ack_q};

	always_comb begin
		case (addr_q)
			OFS_OWN: rd_mux = own_q;
			OFS_RATE: rd_mux = rate_q;
			OFS_CTL: rd_mux = ctl_q;
			OFS_STAT: rd_mux = status;
			OFS_DATA: rd_mux = data_q;
			OFS_CFG: rd_mux = cfg_q;
			OFS_FILT: rd_mux = filter_q;
			OFS_MASK: rd_mux = mask_q;
			default: rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			own_q <= REG_RESET;
			rate_q <= REG_RESET;
			ctl_q <= REG_RESET;
			cfg_q <= REG_RESET;
			filter_q <= REG_RESET;
			mask_q <= MASK_RESET;
		end else begin
			if (wr_en && addr_q == OFS_OWN) own_q <= wdata & OWN_WMASK;
			if (wr_en && addr_q == OFS_RATE) rate_q <= wdata;
			if (wr_en && addr_q == OFS_CTL) begin
				ctl_q <= wdata & CTL_WMASK;
			end else if (m_rs_used_q) begin
				ctl_q[CTL_REPEAT_START_REQUEST] <= 1'b0;
			end
			if (wr_en && addr_q == OFS_CFG) cfg_q <= wdata & CFG_WMASK;
			if (wr_en && addr_q == OFS_FILT) filter_q <= wdata & FILT_WMASK;
			if (wr_en && addr_q == OFS_MASK) mask_q <= wdata & EVENT_BITS;
		end
	end

	// Hardware load beats a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			data_q <= REG_RESET;
		end else if (m_done_q && mrx_q) begin
			data_q <= msh_q;
		end else if (s_done_q || s_aas_q) begin
			data_q <= ssh_q;
		end else if (wr_data) begin
			data_q <= wdata;
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	// Set wins over write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			done_q <= 1'b0;
			aas_q <= 1'b0;
			arbitration_lost_flag_q <= 1'b0;
			irqf_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			done_q <= m_done_q | s_done_q | (done_q & ~(wr_en && addr_q == OFS_STAT && wdata[ST_DONE]));
			aas_q <= s_aas_q | (aas_q & ~(wr_en && addr_q == OFS_STAT && wdata[ST_AAS]));
			arbitration_lost_flag_q <= m_arbitration_lost_flag_q | (arbitration_lost_flag_q & ~(wr_en && addr_q == OFS_STAT && wdata[ST_ARBITRATION_LOST_FLAG]));
			irqf_q <= m_done_q | s_done_q | s_aas_q | m_arbitration_lost_flag_q
				| (irqf_q & ~(wr_en && addr_q == OFS_STAT && wdata[ST_IRQF]));
			irq_q <= ctl_q[CTL_IE] && |(status & mask_q & EVENT_BITS);
		end
	end

	// ----------------------------------------
	// Line synchroniser and glitch filter
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sync1_q <= 2'b11;
			sync2_q <= 2'b11;
		end else begin
			sync1_q <= {scl_in, sda_in};
			sync2_q <= sync1_q;
		end
	end

	// A change must outlast the width before it is accepted
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			filt_q <= 2'b11;
			prev_q <= 2'b11;
			fcnt_q <= '0;
		end else begin
			prev_q <= filt_q;
			for (int i = 0; i < 2; i++) begin
				if (sync2_q[i] == filt_q[i]) begin
					fcnt_q[i] <= 4'h0;
				end else if (fcnt_q[i] >= filter_q[3:0]) begin
					filt_q[i] <= sync2_q[i];
					fcnt_q[i] <= 4'h0;
				end else begin
					fcnt_q[i] <= fcnt_q[i] + 4'h1;
				end
			end
		end
	end

	assign scl_rise = filt_q.scl && !prev_q.scl;
	assign scl_fall = !filt_q.scl && prev_q.scl;
	assign start_det = filt_q.scl && prev_q.scl && prev_q.sda && !filt_q.sda;
	assign stop_det = filt_q.scl && prev_q.scl && !prev_q.sda && filt_q.sda;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
		end else if (stop_det) begin
			busy_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Bit rate
	// ----------------------------------------
	function automatic logic [15:0] half_period(input logic [7:0] f);
		logic [15:0] base;
		base = DIV_BASE + {10'h000, f[5:0]} * DIV_STEP;
		case (f[7:6])
			2'b00: half_period = base;
			2'b01: half_period = base << 1;
			default: half_period = base << 2;
		endcase
	endfunction : half_period

	assign half = half_period(rate_q);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_cnt_q >= half - 16'h0001) begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Master engine
	// ----------------------------------------
	assign go = wr_data && ctl_q[CTL_EN] && ctl_q[CTL_MST];

	always_ff @(posedge ref_clk) begin
		if (!nrst || !ctl_q[CTL_EN]) begin
			mst_q <= M_IDLE;
			mbit_q <= 4'h0;
			msh_q <= 8'h00;
			{mrx_q, mdir_q, maddr_q, m_scl_lo_q, m_sda_lo_q} <= 5'b00000;
			{m_done_q, m_arbitration_lost_flag_q, m_received_ack_q, m_rs_used_q} <= 4'b0000;
		end else begin
			m_done_q <= 1'b0;
			m_arbitration_lost_flag_q <= 1'b0;
			m_rs_used_q <= 1'b0;
			case (mst_q)
				M_IDLE: begin
					if (go && busy_q) begin
						m_arbitration_lost_flag_q <= 1'b1;
					end else if (go) begin
						msh_q <= wdata;
						mdir_q <= wdata[0];
						maddr_q <= 1'b1;
						mrx_q <= 1'b0;
						m_sda_lo_q <= 1'b1;
						mst_q <= M_START;
					end
				end
				M_START: if (tick_q) begin
					m_scl_lo_q <= 1'b1;
					mbit_q <= 4'h0;
					mst_q <= M_LOW;
				end
				// Data settles early in the low phase; on resume from M_WAIT it can change with the SCL release
				M_LOW: begin
					if (mbit_q == 4'h8) m_sda_lo_q <= mrx_q && !ctl_q[CTL_ACK_RESPONSE_SELECT];
					else m_sda_lo_q <= !mrx_q && !msh_q[7];
					if (tick_q) begin
						m_scl_lo_q <= 1'b0;
						mst_q <= M_HIGH;
					end
				end
				M_HIGH: if (tick_q && filt_q.scl) begin
					if (mbit_q == 4'h8) begin
						m_scl_lo_q <= 1'b1;
						m_received_ack_q <= filt_q.sda;
						m_done_q <= 1'b1;
						mbit_q <= 4'h0;
						if (maddr_q) mrx_q <= mdir_q;
						maddr_q <= 1'b0;
						mst_q <= M_WAIT;
					end else if (!mrx_q && msh_q[7] && !filt_q.sda) begin
						m_arbitration_lost_flag_q <= 1'b1;
						m_sda_lo_q <= 1'b0;
						mst_q <= M_IDLE;
					end else begin
						m_scl_lo_q <= 1'b1;
						msh_q <= {msh_q[6:0], filt_q.sda};
						mbit_q <= mbit_q + 4'h1;
						mst_q <= M_LOW;
					end
				end
				M_WAIT: begin
					if (!ctl_q[CTL_MST]) begin
						m_sda_lo_q <= 1'b1;
						mst_q <= M_STOP;
					end else if (go && ctl_q[CTL_REPEAT_START_REQUEST]) begin
						msh_q <= wdata;
						mdir_q <= wdata[0];
						maddr_q <= 1'b1;
						mrx_q <= 1'b0;
						m_sda_lo_q <= 1'b0;
						m_rs_used_q <= 1'b1;
						mst_q <= M_RSTART;
					end else if ((go && !mrx_q) || (rd_data && mrx_q)) begin
						if (!mrx_q) msh_q <= wdata;
						mst_q <= M_LOW;
					end
				end
				M_STOP: if (tick_q) begin
					if (m_scl_lo_q) m_scl_lo_q <= 1'b0;
					else if (filt_q.scl) begin
						m_sda_lo_q <= 1'b0;
						mst_q <= M_IDLE;
					end
				end
				M_RSTART: if (tick_q) begin
					if (m_scl_lo_q) m_scl_lo_q <= 1'b0;
					else if (filt_q.scl) begin
						m_sda_lo_q <= 1'b1;
						mst_q <= M_START;
					end
				end
				default: mst_q <= M_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Slave engine
	// ----------------------------------------
	// 10-bit low byte compares bits 7..1 only, since bit 0 reads zero
	assign own7 = ssh_q[7:1] == own_q[7:1];
	assign gcall = cfg_q[CFG_GCEN] && ssh_q == GEN_CALL;
	assign hdr10 = ssh_q[7:3] == ADDR10_HDR && ssh_q[2:1] == cfg_q[1:0];
	assign smatch = gcall || (cfg_q[CFG_EXT] ? (s10_q ? own7 : hdr10) : own7);

	always_ff @(posedge ref_clk) begin
		if (!nrst || !ctl_q[CTL_EN] || mst_q != M_IDLE || stop_det) begin
			{sact_q, saddr_q, stx_q, s10_q, s_first10_q} <= 5'b00000;
			{s_sda_lo_q, s_hold_q, s_done_q, s_aas_q} <= 4'b0000;
			sbit_q <= 4'h0;
			ssh_q <= 8'h00;
			if (!nrst) s_srw_q <= 1'b0;
		end else if (start_det) begin
			sact_q <= 1'b1;
			saddr_q <= 1'b1;
			stx_q <= 1'b0;
			sbit_q <= 4'hF; // First SCL fall after start carries no bit
			s_sda_lo_q <= 1'b0;
			s_hold_q <= 1'b0;
		end else begin
			s_done_q <= 1'b0;
			s_aas_q <= 1'b0;
			if (sact_q && scl_rise && sbit_q != 4'h8) begin
				ssh_q <= {ssh_q[6:0], filt_q.sda};
				if (stx_q && !s_sda_lo_q && !filt_q.sda) begin
					sact_q <= 1'b0;
					s_sda_lo_q <= 1'b0;
				end
			end else if (sact_q && scl_rise && stx_q && filt_q.sda) begin
				sact_q <= 1'b0;
			end else if (sact_q && scl_fall) begin
				if (sbit_q == 4'hF) begin
					sbit_q <= 4'h0;
				end else if (sbit_q < 4'h7) begin
					sbit_q <= sbit_q + 4'h1;
					s_sda_lo_q <= stx_q && !ssh_q[7];
				end else if (sbit_q == 4'h7) begin
					sbit_q <= 4'h8;
					if (saddr_q && smatch) begin
						s_sda_lo_q <= 1'b1;
						s_aas_q <= 1'b1;
						s_srw_q <= ssh_q[0];
						s_first10_q <= cfg_q[CFG_EXT] && !s10_q && hdr10 && !gcall;
					end else if (saddr_q) begin
						sact_q <= 1'b0;
						s_sda_lo_q <= 1'b0;
					end else begin
						s_sda_lo_q <= !stx_q && !ctl_q[CTL_ACK_RESPONSE_SELECT];
					end
				end else begin
					sbit_q <= 4'h0;
					s_sda_lo_q <= 1'b0;
					s_hold_q <= 1'b1;
					s_done_q <= !saddr_q;
					if (saddr_q) begin
						saddr_q <= s_first10_q;
						s10_q <= s_first10_q;
						stx_q <= s_srw_q && !s_first10_q;
					end
				end
			end
			if (s_hold_q && (wr_data || rd_data)) begin
				s_hold_q <= 1'b0;
				if (wr_data && stx_q) begin
					ssh_q <= wdata;
					s_sda_lo_q <= !wdata[7];
				end
			end
		end
	end

	// ----------------------------------------
	// Pin and bus outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			scl_oe_q <= m_scl_lo_q || s_hold_q;
			sda_oe_q <= m_sda_lo_q || s_sda_lo_q;
			zero_q <= 1'b0;
		end
	end

	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign scl_out = zero_q;
	assign sda_out = zero_q;
	assign irq = irq_q;
	assign hreadyout = hready_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_filter_accept: assert property (
		(sync2_q.sda != filt_q.sda && fcnt_q[0] >= filter_q[3:0])
		|=> filt_q.sda == $past(sync2_q.sda))
		else $error("filter did not accept a settled change");
	a_glitch_absorb: assert property (
		(filter_q[3:0] != 4'h0 && fcnt_q[0] == 4'h0 && sync2_q.sda != filt_q.sda)
		|=> filt_q.sda == $past(filt_q.sda))
		else $error("short excursion passed the filter");
	a_filter_bypass: assert property (
		(filter_q[3:0] == 4'h0 && sync2_q != filt_q) |=> filt_q == $past(sync2_q))
		else $error("zero width did not pass lines through");
	a_rate_tick: assert property (
		tick_q |-> div_cnt_q == 16'h0000 ##1 (!tick_q && div_cnt_q == 16'h0001))
		else $error("half period counter misbehaved");
	a_own_lsb_zero: assert property (
		(pend_q && !wr_q && addr_q == OFS_OWN) |=> (hrdata_q[0] == 1'b0 && hready_q))
		else $error("own address bit 0 not zero");
	a_master_go: assert property (
		(mst_q == M_IDLE && go && !busy_q)
		|=> (mst_q == M_START && m_sda_lo_q && mdir_q == $past(hwdata[0])))
		else $error("data write did not start master transfer");
	a_slave_start: assert property (
		$rose(sact_q) |-> $past(start_det))
		else $error("slave activated without start on the bus");
	a_gcall_flag: assert property (
		(s_aas_q && ssh_q == GEN_CALL) |=> (aas_q && data_q == GEN_CALL))
		else $error("general call not flagged or not readable");
	a_ext_first_irq: assert property (
		(s_aas_q && s_first10_q) |=> (aas_q && irqf_q))
		else $error("10-bit first byte raised no interrupt");

	c_master_start: cover property (mst_q == M_IDLE && go ##1 mst_q == M_START);
	c_slave_addressed: cover property (s_aas_q);
	c_arb_lost: cover property (m_arbitration_lost_flag_q);
endmodule : i2c_smbus_port_filter
